// file: logic/orr_pkg.sv
/*
 * Package for the output ramp timing and status register block.
 * Holds command codes, reset values, field positions and timing counts.
 * Assumes a 20 MHz core clock.
 */
package orr_pkg;

  // Command codes and page of the register bank
  localparam logic [7:0] CMD_ON_DELAY   = 8'h60;
  localparam logic [7:0] CMD_RISE_TIME  = 8'h61;
  localparam logic [7:0] CMD_OFF_DELAY  = 8'h64;
  localparam logic [7:0] CMD_FALL_TIME  = 8'h65;
  localparam logic [7:0] CMD_STATUS     = 8'h78;
  localparam logic [7:0] PAGE_ZERO      = 8'h00;

  // Reset values and ramp time maximum
  localparam logic [15:0] ON_DELAY_RST  = 16'h0000;
  localparam logic [15:0] RISE_TIME_RST = 16'h1388;
  localparam logic [15:0] OFF_DELAY_RST = 16'h0000;
  localparam logic [15:0] FALL_TIME_RST = 16'h1388;
  localparam logic [15:0] RAMP_MAX_US   = 16'h2710;

  // Status summary bit positions
  localparam int ST_BUSY  = 7;
  localparam int ST_OFF   = 6;
  localparam int ST_VOV   = 5;
  localparam int ST_IOC   = 4;
  localparam int ST_VUV   = 3;
  localparam int ST_TEMP  = 2;
  localparam int ST_CML   = 1;
  localparam int ST_OTHER = 0;

  // Timing: clock rate and tick lengths
  localparam int CLK_HZ       = 20000000;
  localparam int TICK_FINE_NS = 1000;
  localparam int TICK_CRSE_NS = 10000;
  localparam int CLK_NS       = 1000000000 / CLK_HZ;
  localparam int FINE_CYC     = TICK_FINE_NS / CLK_NS;
  localparam int CRSE_CYC     = TICK_CRSE_NS / CLK_NS;
  localparam logic [7:0] FINE_CYC_W = 8'(FINE_CYC);
  localparam logic [7:0] CRSE_CYC_W = 8'(CRSE_CYC);

  // Sequencer states
  typedef enum logic [2:0] {
    SEQ_OFF, SEQ_ON_DLY, SEQ_RISE, SEQ_ON, SEQ_OFF_DLY, SEQ_FALL
  } orr_seq_type;

endpackage

// file: logic/orr_tick_cnt.sv
/*
 * Tick counter: counts a number of ticks, each a fixed cycle count.
 * Assumes start is a one-cycle pulse; count and tick length latch then.
 */
`timescale 1ns/1ps
module orr_tick_cnt #(
  parameter int W = 16
) (
  input  wire logic         core_clk_i,  // Core clock
  input  wire logic         rstn_i,      // Sync reset, active low
  input  wire logic         start_i,     // Load count and run
  input  wire logic [W-1:0] ticks_i,     // Number of ticks
  input  wire logic [7:0]   cyc_i,       // Cycles per tick
  output logic              done_o       // Pulse at end of count
);

  logic [W-1:0] tick_q, tick_d;
  logic [7:0]   cyc_q, cyc_d;
  logic [7:0]   per_q, per_d;
  logic         run_q, run_d;
  logic         done_q, done_d;

  // Next state: zero ticks pulses done two cycles after start
  always_comb begin
    tick_d = tick_q;
    cyc_d  = cyc_q;
    per_d  = per_q;
    run_d  = run_q;
    done_d = 1'b0;
    // Tick length latched: the caller's select falls back after start
    if (start_i) begin
      tick_d = ticks_i;
      cyc_d  = 8'h00;
      per_d  = cyc_i;
      run_d  = 1'b1;
    end else if (run_q) begin
      if (tick_q == '0) begin
        run_d  = 1'b0;
        done_d = 1'b1;
      end else if (cyc_q == per_q - 8'h01) begin
        cyc_d  = 8'h00;
        tick_d = tick_q - W'(1);
      end else begin
        cyc_d = cyc_q + 8'h01;
      end
    end
  end

  // Registers
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      tick_q <= '0;
      cyc_q  <= 8'h00;
      per_q  <= 8'h00;
      run_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      tick_q <= tick_d;
      cyc_q  <= cyc_d;
      per_q  <= per_d;
      run_q  <= run_d;
      done_q <= done_d;
    end
  end

  assign done_o = done_q;

endmodule

// file: logic/orr_ramp_regs.sv
/*
 * Output ramp timing registers, enable sequencer and status summary.
 * Assumes a command decoder outside presents page, code and data words,
 * and that fault inputs from the regulator are asynchronous levels.
 */
// Functional notes
// - Rise time register, 16-bit, 1 us steps, reset 1388h, max 10000.
// - Turn-off delay register, 16-bit, 10 us steps, reset zero.
// - Fall time register, 16-bit, 1 us steps, reset 1388h, max 10000.
// - Off delay and fall time apply only when soft off is selected.
// - Ramp timing commands carry two bytes, all bits read and write.
// - Status bit 7 flags a busy fault.
// - Status bit 6 set whenever output is not powered.
// - Status bits 5, 4, 3: output OV, output OC, input UV faults.
// - Bit 2 any temperature fault or warning; bit 1 CML fault.
// - Bit 0 flags any fault not covered by other bits.
// - Status summary is read only.
// - Wait turn-on delay in 10 us steps before rise starts.
`timescale 1ns/1ps
module orr_ramp_regs (
  input  wire logic        core_clk_i,   // Core clock, 20 MHz
  input  wire logic        rstn_i,       // Sync reset, active low
  input  wire logic        wr_i,         // Register write strobe
  input  wire logic        rd_i,         // Register read strobe
  input  wire logic [7:0]  page_i,       // Page of the access
  input  wire logic [7:0]  cmd_i,        // Command code
  input  wire logic [15:0] wdata_i,      // Write data word
  output logic [15:0]      rdata_o,      // Read data word
  output logic             rvalid_o,     // Read data valid pulse
  output logic             cmd_err_o,    // Access refused pulse
  input  wire logic        enable_i,     // Output enable, async level
  input  wire logic        soft_off_i,   // Soft off selected, async
  input  wire logic        busy_flt_i,   // Busy fault, async
  input  wire logic        vout_ov_i,    // Output OV fault, async
  input  wire logic        iout_oc_i,    // Output OC fault, async
  input  wire logic        vin_uv_i,     // Input UV fault, async
  input  wire logic        temp_i,       // Temperature fault/warn
  input  wire logic        cml_i,        // Comms/memory/logic fault
  input  wire logic        other_flt_i,  // Any other fault
  output logic             ramp_up_o,    // Output rising
  output logic             ramp_down_o,  // Output falling
  output logic             pwr_on_o,     // Output powered
  output logic [15:0]      ramp_us_o     // Active ramp time, us
);

  localparam int NSYNC = 9;

  logic [15:0]       on_dly_q, on_dly_d;
  logic [15:0]       rise_q, rise_d;
  logic [15:0]       off_dly_q, off_dly_d;
  logic [15:0]       fall_q, fall_d;
  logic [15:0]       rdata_q, rdata_d;
  logic              rvalid_q, rvalid_d;
  logic              err_q, err_d;
  logic [NSYNC-1:0]  async_in;
  logic [NSYNC-1:0]  sync1_q, sync2_q;
  logic              en_s, soft_s;
  logic [7:0]        status;
  orr_pkg::orr_seq_type st_q, st_d;
  logic              t_start;
  logic [15:0]       t_ticks;
  logic [7:0]        t_cyc;
  logic              t_done;
  logic [15:0]       ramp_q, ramp_d;

  // Clamp ramp times at the supported maximum
  function automatic logic [15:0] clamp_ramp(input logic [15:0] v);
    clamp_ramp = (v > orr_pkg::RAMP_MAX_US) ? orr_pkg::RAMP_MAX_US : v;
  endfunction

  // Two-flop synchronisers for every async input
  assign async_in = {enable_i, soft_off_i, busy_flt_i, vout_ov_i,
                     iout_oc_i, vin_uv_i, temp_i, cml_i, other_flt_i};
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
    end
  end
  assign en_s   = sync2_q[8];
  assign soft_s = sync2_q[7];

  // Status summary assembled from synchronised levels; bit 6 from the sequencer state
  always_comb begin
    status = 8'h00;
    status[orr_pkg::ST_BUSY]  = sync2_q[6];
    status[orr_pkg::ST_OFF]   = (st_q != orr_pkg::SEQ_ON);
    status[orr_pkg::ST_VOV]   = sync2_q[5];
    status[orr_pkg::ST_IOC]   = sync2_q[4];
    status[orr_pkg::ST_VUV]   = sync2_q[3];
    status[orr_pkg::ST_TEMP]  = sync2_q[2];
    status[orr_pkg::ST_CML]   = sync2_q[1];
    status[orr_pkg::ST_OTHER] = sync2_q[0];
  end

  // Register writes and reads; wrong page is refused
  always_comb begin
    on_dly_d  = on_dly_q;
    rise_d    = rise_q;
    off_dly_d = off_dly_q;
    fall_d    = fall_q;
    rdata_d   = rdata_q;
    rvalid_d  = 1'b0;
    err_d     = 1'b0;
    if ((wr_i || rd_i) && page_i != orr_pkg::PAGE_ZERO) begin
      err_d = 1'b1;
    end else if (wr_i) begin
      case (cmd_i)
        orr_pkg::CMD_ON_DELAY:  on_dly_d  = wdata_i;
        orr_pkg::CMD_RISE_TIME: rise_d    = wdata_i;
        orr_pkg::CMD_OFF_DELAY: off_dly_d = wdata_i;
        orr_pkg::CMD_FALL_TIME: fall_d    = wdata_i;
        default:                err_d     = 1'b1;
      endcase
    end else if (rd_i) begin
      rvalid_d = 1'b1;
      case (cmd_i)
        orr_pkg::CMD_ON_DELAY:  rdata_d = on_dly_q;
        orr_pkg::CMD_RISE_TIME: rdata_d = rise_q;
        orr_pkg::CMD_OFF_DELAY: rdata_d = off_dly_q;
        orr_pkg::CMD_FALL_TIME: rdata_d = fall_q;
        orr_pkg::CMD_STATUS:    rdata_d = {8'h00, status};
        default: begin
          rdata_d  = 16'h0000;
          rvalid_d = 1'b0;
          err_d    = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      on_dly_q  <= orr_pkg::ON_DELAY_RST;
      rise_q    <= orr_pkg::RISE_TIME_RST;
      off_dly_q <= orr_pkg::OFF_DELAY_RST;
      fall_q    <= orr_pkg::FALL_TIME_RST;
      rdata_q   <= 16'h0000;
      rvalid_q  <= 1'b0;
      err_q     <= 1'b0;
    end else begin
      on_dly_q  <= on_dly_d;
      rise_q    <= rise_d;
      off_dly_q <= off_dly_d;
      fall_q    <= fall_d;
      rdata_q   <= rdata_d;
      rvalid_q  <= rvalid_d;
      err_q     <= err_d;
    end
  end

  // Enable sequencer; timer settings sampled at each phase start
  always_comb begin
    st_d    = st_q;
    t_start = 1'b0;
    t_ticks = 16'h0000;
    t_cyc   = orr_pkg::FINE_CYC_W;
    ramp_d  = ramp_q;
    case (st_q)
      orr_pkg::SEQ_OFF: begin
        if (en_s) begin
          st_d    = orr_pkg::SEQ_ON_DLY;
          t_start = 1'b1;
          t_ticks = on_dly_q;
          t_cyc   = orr_pkg::CRSE_CYC_W;
        end
      end
      orr_pkg::SEQ_ON_DLY: begin
        if (!en_s) begin
          st_d = orr_pkg::SEQ_OFF;
        end else if (t_done) begin
          st_d    = orr_pkg::SEQ_RISE;
          t_start = 1'b1;
          t_ticks = clamp_ramp(rise_q);
          ramp_d  = clamp_ramp(rise_q);
        end
      end
      orr_pkg::SEQ_RISE: begin
        if (t_done) begin
          st_d = orr_pkg::SEQ_ON;
        end
      end
      orr_pkg::SEQ_ON: begin
        if (!en_s) begin
          if (soft_s) begin
            st_d    = orr_pkg::SEQ_OFF_DLY;
            t_start = 1'b1;
            t_ticks = off_dly_q;
            t_cyc   = orr_pkg::CRSE_CYC_W;
          end else begin
            st_d   = orr_pkg::SEQ_OFF;
            ramp_d = 16'h0000;
          end
        end
      end
      orr_pkg::SEQ_OFF_DLY: begin
        if (t_done) begin
          st_d    = orr_pkg::SEQ_FALL;
          t_start = 1'b1;
          t_ticks = clamp_ramp(fall_q);
          ramp_d  = clamp_ramp(fall_q);
        end
      end
      orr_pkg::SEQ_FALL: begin
        if (t_done) begin
          st_d   = orr_pkg::SEQ_OFF;
          ramp_d = 16'h0000;
        end
      end
      default: st_d = orr_pkg::SEQ_OFF;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      st_q   <= orr_pkg::SEQ_OFF;
      ramp_q <= 16'h0000;
    end else begin
      st_q   <= st_d;
      ramp_q <= ramp_d;
    end
  end

  // Shared timer for delays and ramps
  orr_tick_cnt #(
    .W (16)
  ) u_timer (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .start_i    (t_start),
    .ticks_i    (t_ticks),
    .cyc_i      (t_cyc),
    .done_o     (t_done)
  );

  assign rdata_o     = rdata_q;
  assign rvalid_o    = rvalid_q;
  assign cmd_err_o   = err_q;
  assign ramp_up_o   = (st_q == orr_pkg::SEQ_RISE);
  assign ramp_down_o = (st_q == orr_pkg::SEQ_FALL);
  assign pwr_on_o    = (st_q != orr_pkg::SEQ_OFF)
                    && (st_q != orr_pkg::SEQ_ON_DLY);
  assign ramp_us_o   = ramp_q;

endmodule

// file: verif/orr_ramp_regs_sva.sv
/* Port checker for orr_ramp_regs.
   Assumes the bind below; sync reset, active low. */
`timescale 1ns/1ps
module orr_ramp_regs_sva (
  input wire logic        core_clk_i,  // Clock
  input wire logic        rstn_i,      // Reset
  input wire logic        wr_i,        // Write
  input wire logic        rd_i,        // Read
  input wire logic [7:0]  page_i,      // Page
  input wire logic [7:0]  cmd_i,       // Code
  input wire logic [15:0] rdata_o,     // Data
  input wire logic        rvalid_o,    // Answer
  input wire logic        cmd_err_o,   // Refusal
  input wire logic        ramp_up_o,   // Rise
  input wire logic        ramp_down_o, // Fall
  input wire logic        pwr_on_o,    // Powered
  input wire logic [15:0] ramp_us_o    // Ramp time
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  // Page-zero read, then a status read while unpowered
  sequence s_rd(c);
    rd_i && !wr_i && page_i == 8'h00 && cmd_i == c;
  endsequence
  sequence s_st_off;
    s_rd(8'h78) ##0 !pwr_on_o ##1 !pwr_on_o;
  endsequence
  // Bus answers a cycle on; ramps only while powered
  property p_rd; s_rd(8'h61) |=> rvalid_o && !cmd_err_o; endproperty
  a_rd: assert property (p_rd) else $error("read unanswered");
  property p_pg; wr_i && page_i != 8'h00 |=> cmd_err_o; endproperty
  a_pg: assert property (p_pg) else $error("page kept");
  property p_ro; wr_i && page_i == 8'h00 && cmd_i == 8'h78 |=> cmd_err_o;
  endproperty
  a_ro: assert property (p_ro) else $error("status written");
  property p_off; s_st_off |-> rdata_o[6] && rdata_o[15:8] == 8'h00;
  endproperty
  a_off: assert property (p_off) else $error("off bit clear");
  property p_max; ramp_up_o || ramp_down_o |-> ramp_us_o <= 16'h2710;
  endproperty
  a_max: assert property (p_max) else $error("ramp over max");
  property p_rise; $rose(ramp_up_o) |-> $rose(pwr_on_o) && !ramp_down_o;
  endproperty
  a_rise: assert property (p_rise) else $error("rise misplaced");
  property p_fall; $fell(ramp_down_o) |-> !pwr_on_o; endproperty
  a_fall: assert property (p_fall) else $error("fall end on");
  property p_idle; !pwr_on_o |-> !ramp_up_o && !ramp_down_o
    && ramp_us_o == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("ramp while off");
endmodule
bind orr_ramp_regs orr_ramp_regs_sva u_orr_ramp_regs_sva (.*);

// file: verif/orr_host_model.sv
/* Register host model for orr_ramp_regs.
   Assumes one access at a time, driven on falling edges. */
`timescale 1ns/1ps
module orr_host_model (
  input  wire logic        core_clk_i,         // Clock
  output logic             wr_o = 1'h0,        // Write
  output logic             rd_o = 1'h0,        // Read
  output logic [7:0]       page_o = 8'h00,     // Page
  output logic [7:0]       cmd_o = 8'h00,      // Code
  output logic [15:0]      wdata_o = 16'h0000, // Word
  input  wire logic [15:0] rdata_i,            // Read word
  input  wire logic        rvalid_i,           // Answer
  input  wire logic        cmd_err_i           // Refusal
);
  task automatic xfer(input logic w, input logic [7:0] p, c,
    input logic [15:0] d, output logic [15:0] q, output logic v, er);
    @(negedge core_clk_i);
    wr_o = w;
    rd_o = !w;
    page_o = p;
    cmd_o = c;
    wdata_o = d;
    @(negedge core_clk_i);
    q = rdata_i;
    v = rvalid_i;
    er = cmd_err_i;
    wr_o = 1'h0;
    rd_o = 1'h0;
    // Released lines flip, so stale values never look valid
    page_o = ~p;
    cmd_o = ~c;
    wdata_o = ~d;
  endtask
endmodule

// file: verif/orr_ramp_regs_tb.sv
/* Bench for orr_ramp_regs: registers, status, sequencing.
   Assumes orr_host_model and the bound checker. */
`timescale 1ns/1ps
module orr_ramp_regs_tb;
  logic        clk = 1'h0, rstn = 1'h0, en = 1'h0, sf = 1'h0;
  logic        wr, rd, rv, er, up, dn, pon, v, e;
  logic [6:0]  f = 7'h00;
  logic [7:0]  pg, cm;
  logic [15:0] wd, rdt, rus, q;
  int          n, n_fail = 0, samples_checked = 0, cyc = 0;
  int          bp[7] = '{7, 5, 4, 3, 2, 1, 0};
  logic [7:0]  rg[4] = '{8'h60, 8'h61, 8'h64, 8'h65};
  logic [15:0] dv[4] = '{16'h0000, 16'h1388, 16'h0000, 16'h1388};
  // 20 MHz clock
  always #25 clk = ~clk;
  orr_ramp_regs u_orr_ramp_regs (
    .core_clk_i(clk), .rstn_i(rstn), .wr_i(wr), .rd_i(rd), .page_i(pg),
    .cmd_i(cm), .wdata_i(wd), .rdata_o(rdt), .rvalid_o(rv), .cmd_err_o(er),
    .enable_i(en), .soft_off_i(sf), .busy_flt_i(f[0]), .vout_ov_i(f[1]),
    .iout_oc_i(f[2]), .vin_uv_i(f[3]), .temp_i(f[4]), .cml_i(f[5]),
    .other_flt_i(f[6]), .ramp_up_o(up), .ramp_down_o(dn), .pwr_on_o(pon),
    .ramp_us_o(rus));
  orr_host_model u_orr_host_model (
    .core_clk_i(clk), .wr_o(wr), .rd_o(rd), .page_o(pg), .cmd_o(cm),
    .wdata_o(wd), .rdata_i(rdt), .rvalid_i(rv), .cmd_err_i(er));
  // Compare and count
  task automatic chk(input string nm, input logic [15:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask
  // Verdict, then end of run
  task final_report;
    if (n_fail == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Bounded wait for a level, counting falling edges
  task automatic wt(ref logic s, input logic lvl);
    n = 0;
    while (s !== lvl && n < 3000) begin
      @(negedge clk);
      n++;
    end
    // A wait that runs out counts as a mismatch
    chk("wait", 16'(s === lvl), 16'h0001);
  endtask
  task automatic ac(input logic w, input logic [7:0] c, input logic [15:0] d);
    u_orr_host_model.xfer(w, 8'h00, c, d, q, v, e);
  endtask
  task t_rw;
    for (int i = 0; i < 4; i++) begin
      ac(1'h0, rg[i], 16'h0000);
      chk("reset", q, dv[i]);
      ac(1'h1, rg[i], 16'hFFFF);
      u_orr_host_model.xfer(1'h1, 8'h01, rg[i], 16'h0000, q, v, e);
      chk("page_err", 16'(e), 16'h0001);
      u_orr_host_model.xfer(1'h0, 8'h01, rg[i], 16'h0000, q, v, e);
      chk("page_rd_err", 16'({v, e}), 16'h0001);
      ac(1'h0, rg[i], 16'h0000);
      chk("rw_ones", q, 16'hFFFF);
      ac(1'h1, rg[i], 16'h0000);
      ac(1'h0, rg[i], 16'h0000);
      chk("rw_zero", q, 16'h0000);
    end
    ac(1'h1, 8'h78, 16'hFFFF);
    chk("ro_err", 16'(e), 16'h0001);
    ac(1'h0, 8'h7F, 16'h0000);
    chk("unk_err", 16'({v, e}), 16'h0001);
  endtask
  task t_st;
    for (int i = 0; i < 7; i++) begin
      f[i] = 1'h1;
      repeat (4) @(negedge clk);
      ac(1'h0, 8'h78, 16'h0000);
      chk("status", q, 16'h0040 | (16'h0001 << bp[i]));
      f[i] = 1'h0;
      repeat (4) @(negedge clk);
    end
  endtask
  task t_seq;
    ac(1'h1, 8'h60, 16'h0002);
    ac(1'h1, 8'h61, 16'h0003);
    ac(1'h1, 8'h64, 16'h0001);
    ac(1'h1, 8'h65, 16'h0002);
    sf = 1'h1;
    en = 1'h1;
    wt(pon, 1'h1);
    chk("on_dly", 16'(n >= 400 && n <= 410), 16'h0001);
    chk("rise_us", rus, 16'h0003);
    wt(up, 1'h0);
    // 3 us is 60 cycles; the timer adds up to two cycles of latency
    chk("rise_len", 16'(n >= 60 && n <= 62), 16'h0001);
    ac(1'h0, 8'h78, 16'h0000);
    chk("st_on", q, 16'h0000);
    en = 1'h0;
    wt(dn, 1'h1);
    chk("off_dly", 16'(n >= 200 && n <= 206), 16'h0001);
    chk("fall_us", rus, 16'h0002);
    wt(dn, 1'h0);
    chk("fall_len", 16'(n >= 40 && n <= 42), 16'h0001);
    repeat (6) @(negedge clk);
    sf = 1'h0;
    en = 1'h1;
    wt(up, 1'h1);
    wt(up, 1'h0);
    en = 1'h0;
    wt(pon, 1'h0);
    chk("hard_off", 16'(n <= 5 && dn == 1'h0), 16'h0001);
  endtask
  // Cycle ceiling against hangs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      final_report;
    end
  end
  // Reset for 20 cycles, then the scenarios
  initial begin
    repeat (20) @(negedge clk);
    rstn = 1'h1;
    t_rw;
    t_st;
    t_seq;
    final_report;
  end
endmodule
